//--- core/ident_err_pkg.sv
/*
 Shared constants and types of the identity and error object bank.
 Assumes a single 25 MHz clock and a plain strobe register port.
*/
package ident_err_pkg;
	// Register byte addresses: object index times four
	localparam logic [15:0] IDX_IDENT = 16'h1000;
	localparam logic [15:0] IDX_SUMMARY = 16'h1001;
	localparam logic [15:0] IDX_COUNT = 16'h1003;
	localparam logic [17:0] ADDR_IDENT = {IDX_IDENT, 2'b00};
	localparam logic [17:0] ADDR_SUMMARY = {IDX_SUMMARY, 2'b00};
	localparam logic [17:0] ADDR_COUNT = {IDX_COUNT, 2'b00};
	// History entries 1..8 follow at 0x4010 + 4*n
	localparam logic [17:0] ADDR_HIST_BASE = 18'h04010;
	localparam logic [17:0] ADDR_IRQ_STATUS = 18'h04040;
	localparam logic [17:0] ADDR_IRQ_MASK = 18'h04044;
	localparam logic [17:0] ADDR_ABORT = 18'h04048;
	// Identification fields
	localparam int MOTOR_LSB = 16;
	localparam int PROFILE_LSB = 0;
	localparam logic [7:0] MOTOR_BLDC = 8'h02;
	localparam logic [7:0] MOTOR_STEPPER = 8'h04;
	localparam logic [7:0] MOTOR_BOTH = 8'h06;
	localparam logic [15:0] PROFILE_NUM = 16'h0192;
	// Summary bit positions
	localparam int GENERAL_FAULT_BIT = 0;
	localparam int CURRENT_FAULT_BIT = 1;
	localparam int VOLTAGE_FAULT_BIT = 2;
	localparam int TEMP_FAULT_BIT = 3;
	localparam int COMMS_FAULT_BIT = 4;
	localparam int PROFILE_FAULT_BIT = 5;
	localparam int RESERVED_ZERO_BIT = 6;
	localparam int VENDOR_FAULT_BIT = 7;
	localparam logic [7:0] SUMMARY_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [31:0] ENTRY_RESET = 32'h00000000;
	localparam logic [31:0] ABORT_EMPTY = 32'h08000024;
	localparam int HIST_DEPTH = 8;
	// Interrupt bits
	localparam int IRQ_NEW_ERROR = 0;
	localparam int IRQ_EMPTY_READ = 1;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	// Detailed error entry
	typedef struct packed {
		logic [7:0] cause;
		logic [7:0] err_class;
		logic [15:0] code;
	} err_entry_t;
	// Register port request
	typedef struct packed {
		logic [17:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
endpackage

//--- core/reset_sync.sv
/*
 Two-stage release synchroniser for the active-low reset.
 Assumes an asynchronous reset pin on the single clock.
*/
`timescale 1ns/100ps
`default_nettype none
module reset_sync (
	input wire logic i_mclk,
	input wire logic i_arst_n,
	output logic o_rst_n
);
	logic stage;

	// Assert at once, release after two edges
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			stage <= 1'b0;
			o_rst_n <= 1'b0;
		end
		else
		begin
			stage <= 1'b1;
			o_rst_n <= stage;
		end
	end
endmodule
`default_nettype wire

//--- core/err_history.sv
/*
 Eight-deep error history shift stack with registered read port.
 Assumes pushes and clears come from the owning bank on its clock.
*/
`timescale 1ns/100ps
`default_nettype none
module err_history #(
	parameter int DEPTH = 8
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_push,
	input wire ident_err_pkg::err_entry_t i_entry,
	input wire logic i_clear,
	input wire logic [2:0] i_rd_pos,
	output ident_err_pkg::err_entry_t o_rd_data
);
	import ident_err_pkg::*;

	initial
	begin
		if (DEPTH != 8)
			$error("err_history supports only eight entries");
	end

	err_entry_t mem [DEPTH];
	err_entry_t next_mem [DEPTH];
	err_entry_t next_rd_data;

	// New entry at the top, older ones slide down, last falls off
	always_comb
	begin
		for (int i = 0; i < DEPTH; i++)
			next_mem[i] = mem[i];
		if (i_clear)
		begin
			for (int i = 0; i < DEPTH; i++)
				next_mem[i] = ENTRY_RESET;
		end
		if (i_push)
		begin
			next_mem[0] = i_entry;
			for (int i = 1; i < DEPTH; i++)
				next_mem[i] = i_clear ? ENTRY_RESET : mem[i-1];
		end
		next_rd_data = mem[i_rd_pos];
	end

	// Entries preset to zero at start
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= ENTRY_RESET;
			o_rd_data <= ENTRY_RESET;
		end
		else
		begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= next_mem[i];
			o_rd_data <= next_rd_data;
		end
	end

	AST_SHIFT_DOWN: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_push && !i_clear) |=> mem[1] == $past(mem[0]) && mem[0] == $past(i_entry))
		else $error("history did not shift on push");
endmodule
`default_nettype wire

//--- core/ident_err_bank.sv
/*
 Identity and error object bank: identification word, summary error
 register, eight-entry error history with count, interrupt status/mask.
 Assumes fault level inputs and error events are synchronous to i_mclk.
*/
// The strobed register port is this design's own decision.
// What this block does
// - Identification bits 23..16 give motor kind: 2, 4 or 6.
// - Identification bits 15..0 hold profile number 0x0192.
// - Summary bit set while its category fault is active, reset zero.
// - Summary bits: general..profile at 0..5, reserved 6 zero, vendor 7.
// - History holds up to eight; writable 8-bit count, preset zero.
// - Every raised error records a detailed 32-bit code in history.
// - History entries 1..8 are 32-bit, read-only, preset zero.
// - New error goes to entry 1; older entries shift down one.
// - Writing zero to count restarts; empty-history reads return abort.
// - Entry layout: cause 31..24, class 23..16, code 15..0.
`timescale 1ns/100ps
`default_nettype none
module ident_err_bank #(
	parameter logic [7:0] MOTOR_KIND = 8'h06
) (
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic [17:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_fault_active,
	input wire logic i_err_event,
	input wire ident_err_pkg::err_entry_t i_err_entry,
	output logic [31:0] o_rdata,
	output logic o_rd_abort,
	output logic [7:0] o_summary,
	output logic o_irq
);
	import ident_err_pkg::*;

	initial
	begin
		if (MOTOR_KIND != MOTOR_BLDC && MOTOR_KIND != MOTOR_STEPPER &&
			MOTOR_KIND != MOTOR_BOTH)
			$error("MOTOR_KIND must be 2, 4 or 6");
	end

	logic rst_n;
	reg_req_t req;
	logic [7:0] count;
	logic [7:0] next_count;
	logic [7:0] next_summary;
	logic [1:0] irq_status;
	logic [1:0] next_irq_status;
	logic [1:0] irq_mask;
	logic [1:0] next_irq_mask;
	logic [31:0] next_rdata;
	logic next_rd_abort;
	logic next_irq;
	logic rd_hist;
	logic rd_hist_q;
	logic rd_empty_q;
	logic [31:0] mux_q;
	logic [31:0] next_mux;
	logic hist_clear;
	logic hist_sel;
	logic [2:0] hist_pos;
	logic empty_read;
	err_entry_t hist_data;

	reset_sync u_reset_sync (
		.i_mclk(i_mclk),
		.i_arst_n(i_arst_n),
		.o_rst_n(rst_n)
	);

	assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	// Entries 1..8 map to 0x4014..0x4030
	function automatic logic is_hist(input logic [17:0] a);
		return a >= ADDR_HIST_BASE + 18'h00004 &&
			a <= ADDR_HIST_BASE + 18'h00020 && a[1:0] == 2'b00;
	endfunction

	function automatic logic [2:0] hist_index(input logic [17:0] a);
		logic [17:0] off;
		off = a - ADDR_HIST_BASE - 18'h00004;
		return off[4:2];
	endfunction

	assign hist_sel = is_hist(req.addr);
	assign hist_pos = hist_index(req.addr);
	assign rd_hist = req.rd && hist_sel;
	assign empty_read = rd_hist && count == COUNT_RESET;
	assign hist_clear = req.wr && req.addr == ADDR_COUNT &&
		req.wdata[7:0] == COUNT_RESET;

	err_history #(
		.DEPTH(HIST_DEPTH)
	) u_err_history (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n),
		.i_push(i_err_event),
		.i_entry(i_err_entry),
		.i_clear(hist_clear),
		.i_rd_pos(hist_pos),
		.o_rd_data(hist_data)
	);

	// Count, summary and interrupt next values
	always_comb
	begin
		next_count = count;
		if (req.wr && req.addr == ADDR_COUNT)
			next_count = req.wdata[7:0];
		// Event counts on top of a same-cycle write, rising only below depth
		if (i_err_event)
		begin
			if (hist_clear)
				next_count = 8'h01;
			else if (next_count < 8'(HIST_DEPTH))
				next_count = next_count + 8'h01;
		end
		next_summary = i_fault_active;
		next_summary[RESERVED_ZERO_BIT] = 1'b0;
		next_irq_mask = irq_mask;
		if (req.wr && req.addr == ADDR_IRQ_MASK)
			next_irq_mask = req.wdata[1:0];
		next_irq_status = irq_status;
		if (req.wr && req.addr == ADDR_IRQ_STATUS)
			next_irq_status = irq_status & ~req.wdata[1:0];
		// Set beats clear so no event is lost
		if (i_err_event)
			next_irq_status[IRQ_NEW_ERROR] = 1'b1;
		if (empty_read)
			next_irq_status[IRQ_EMPTY_READ] = 1'b1;
		next_irq = |(next_irq_status & next_irq_mask);
	end

	// Read mux stage one: decode the address
	always_comb
	begin
		next_mux = 32'h00000000;
		if (req.rd)
		begin
			case (req.addr)
				ADDR_IDENT: next_mux = {8'h00, MOTOR_KIND, PROFILE_NUM};
				ADDR_SUMMARY: next_mux = {24'h000000, o_summary};
				ADDR_COUNT: next_mux = {24'h000000, count};
				ADDR_IRQ_STATUS: next_mux = {30'h00000000, irq_status};
				ADDR_IRQ_MASK: next_mux = {30'h00000000, irq_mask};
				default: next_mux = 32'h00000000;
			endcase
		end
	end

	// History data arrive a cycle late from the stack's register
	always_comb
	begin
		next_rdata = mux_q;
		next_rd_abort = 1'b0;
		if (rd_empty_q)
		begin
			next_rdata = ABORT_EMPTY;
			next_rd_abort = 1'b1;
		end
		else if (rd_hist_q)
			next_rdata = hist_data;
	end

	// Register everything; read data are valid one cycle after strobe
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count <= COUNT_RESET;
			o_summary <= SUMMARY_RESET;
			irq_status <= IRQ_RESET;
			irq_mask <= IRQ_RESET;
			o_irq <= 1'b0;
			mux_q <= 32'h00000000;
			rd_hist_q <= 1'b0;
			rd_empty_q <= 1'b0;
		end
		else
		begin
			count <= next_count;
			o_summary <= next_summary;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			o_irq <= next_irq;
			mux_q <= next_mux;
			rd_hist_q <= rd_hist;
			rd_empty_q <= empty_read;
		end
	end

	// Output stage: the mux result is held until the strobe's next cycle
	assign o_rdata = next_rdata;
	assign o_rd_abort = next_rd_abort;

	AST_SUMMARY_FOLLOWS: assert property (@(posedge i_mclk) disable iff (!rst_n)
		##1 o_summary == ($past(i_fault_active) & 8'hbf))
		else $error("summary does not follow fault levels");
	AST_RESERVED_ZERO: assert property (@(posedge i_mclk) disable iff (!rst_n)
		o_summary[RESERVED_ZERO_BIT] == 1'b0)
		else $error("reserved summary bit set");
	AST_IDENT_WORD: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(req.rd && req.addr == ADDR_IDENT) |=> o_rdata == 32'h00000192 +
		{8'h00, MOTOR_KIND, 16'h0000})
		else $error("identification word wrong");
	AST_COUNT_CAP: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(i_err_event && !req.wr && count == 8'h08) |=> count == 8'h08)
		else $error("count passed eight");
	AST_COUNT_INC: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(i_err_event && !req.wr && count < 8'h08) |=> count == $past(count) + 8'h01)
		else $error("count did not rise on error");
	AST_ZERO_RESTART: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(hist_clear && !i_err_event) |=> count == 8'h00)
		else $error("zero write did not restart count");
	AST_EMPTY_ABORT: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(rd_hist && count == 8'h00) |=> o_rd_abort && o_rdata == 32'h08000024)
		else $error("empty history read not aborted");
	AST_ENTRY_READ: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(i_err_event && !hist_clear) ##1 (req.rd && req.addr == 18'h04014 && !i_err_event)
		|=> o_rdata == $past(i_err_entry, 2))
		else $error("entry one does not hold newest error");
endmodule
`default_nettype wire

//--- testbench/fb_master.sv
/*
 Register-port master model standing in for the fieldbus side.
 Assumes the slave answers reads in the cycle after the strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module fb_master (
	input wire logic i_mclk,
	output logic [17:0] o_addr,
	output logic [31:0] o_wdata,
	output logic o_wr,
	output logic o_rd,
	input wire logic [31:0] i_rdata,
	input wire logic i_rd_abort
);
	initial
	begin
		o_addr = 18'h00000;
		o_wdata = 32'h00000000;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// One-cycle write; address inverted after so nothing leans on it
	task automatic write_reg(input logic [17:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_mclk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
	// Data taken in the cycle after the strobe, the only valid one
	task automatic read_reg(input logic [17:0] a, output logic [31:0] d,
		output logic ab);
		@(posedge i_mclk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_mclk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		#1;
		d = i_rdata;
		ab = i_rd_abort;
	endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
/*
 Self-checking bench of the identity and error object bank.
 Assumes the master model drives the register port.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) \
	begin compares++; if ((got) !== (ex)) begin fail_count++; \
	$display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module tb_top;
	import ident_err_pkg::*;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [17:0] addr;
	logic [31:0] wdata, rdata, d;
	logic wr, rd, rd_abort, irq, ab, ev = 1'b0;
	logic [7:0] fault = 8'h00, summary;
	err_entry_t entry = '0;
	int fail_count = 0;
	int compares = 0;
	always #20 mclk = ~mclk;
	fb_master i_master (.i_mclk(mclk), .o_addr(addr), .o_wdata(wdata),
		.o_wr(wr), .o_rd(rd), .i_rdata(rdata), .i_rd_abort(rd_abort));
	ident_err_bank #(.MOTOR_KIND(MOTOR_STEPPER)) i_dut (.i_mclk(mclk),
		.i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .i_fault_active(fault), .i_err_event(ev),
		.i_err_entry(entry), .o_rdata(rdata), .o_rd_abort(rd_abort),
		.o_summary(summary), .o_irq(irq));
	task automatic give_verdict();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic rd_chk(input logic [17:0] a, input logic [31:0] ex);
		i_master.read_reg(a, d, ab);
		`CHK("rdata", ex, d)
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Presets after start, empty-history aborts, unmapped read
	task automatic t_reset_values();
		rd_chk(ADDR_IDENT, {8'h00, MOTOR_STEPPER, PROFILE_NUM});
		rd_chk(ADDR_SUMMARY, 32'(SUMMARY_RESET));
		rd_chk(ADDR_COUNT, 32'(COUNT_RESET));
		for (int n = 1; n <= HIST_DEPTH; n++)
		begin
			rd_chk(ADDR_HIST_BASE + 18'(4 * n), ABORT_EMPTY);
			`CHK("abort", 1'b1, ab)
		end
		rd_chk(ADDR_ABORT, 32'h00000000);
	endtask
	// Each category bit follows its fault level; reserved stays low
	task automatic t_summary();
		for (int b = 0; b < 8; b++)
		begin
			@(posedge mclk);
			fault <= 8'(1 << b);
			settle(2);
			`CHK("summary", (b == RESERVED_ZERO_BIT) ? 8'h00 : 8'(1 << b), summary)
			rd_chk(ADDR_SUMMARY, {24'h0, (b == RESERVED_ZERO_BIT) ? 8'h00 : 8'(1 << b)});
		end
		@(posedge mclk);
		fault <= 8'hff;
		settle(2);
		`CHK("summary", 8'hbf, summary)
		@(posedge mclk);
		fault <= 8'h00;
		settle(2);
		`CHK("summary", 8'h00, summary)
	endtask
	// Nine pushes: newest on top, oldest falls off, count saturates
	task automatic t_history();
		for (int k = 1; k <= 9; k++)
		begin
			@(posedge mclk);
			ev <= 1'b1;
			entry <= {8'(k), 8'ha5, 16'hc000 + 16'(k)};
			@(posedge mclk);
			ev <= 1'b0;
		end
		rd_chk(ADDR_COUNT, 32'h8);
		for (int n = 1; n <= HIST_DEPTH; n++)
		begin
			rd_chk(ADDR_HIST_BASE + 18'(4 * n), {8'(10 - n), 8'ha5, 16'hc000 + 16'(10 - n)});
			`CHK("abort", 1'b0, ab)
		end
		i_master.write_reg(ADDR_HIST_BASE + 18'h4, 32'hffffffff);
		rd_chk(ADDR_HIST_BASE + 18'h4, {8'h09, 8'ha5, 16'hc009});
		i_master.write_reg(ADDR_COUNT, 32'h5);
		rd_chk(ADDR_COUNT, 32'h5);
		i_master.write_reg(ADDR_COUNT, 32'h0);
		rd_chk(ADDR_COUNT, 32'h0);
		rd_chk(ADDR_HIST_BASE + 18'h4, ABORT_EMPTY);
		// Read of entry one right behind a fresh error after the restart
		@(posedge mclk);
		ev <= 1'b1;
		entry <= {8'h1f, 8'h3c, 16'h0bad};
		fork
			i_master.read_reg(ADDR_HIST_BASE + 18'h4, d, ab);
			begin
				@(posedge mclk);
				ev <= 1'b0;
			end
		join
		`CHK("entry", {8'h1f, 8'h3c, 16'h0bad}, d)
		`CHK("abort", 1'b0, ab)
		rd_chk(ADDR_COUNT, 32'h1);
	endtask
	// Sticky status, mask gating, write-one-to-clear
	task automatic t_irq();
		rd_chk(ADDR_IRQ_STATUS, 32'h3);
		`CHK("irq", 1'b0, irq)
		i_master.write_reg(ADDR_IRQ_MASK, 32'h2);
		settle(2);
		`CHK("irq", 1'b1, irq)
		i_master.write_reg(ADDR_IRQ_STATUS, 32'h2);
		settle(2);
		`CHK("irq", 1'b0, irq)
		i_master.write_reg(ADDR_IRQ_MASK, 32'h1);
		settle(2);
		`CHK("irq", 1'b1, irq)
		i_master.write_reg(ADDR_IRQ_STATUS, 32'h1);
		settle(2);
		`CHK("irq", 1'b0, irq)
		rd_chk(ADDR_IRQ_STATUS, 32'h0);
	endtask
	// Watchdog, far beyond the expected run length
	initial
	begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		give_verdict();
	end
	initial
	begin
		repeat (20) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		t_reset_values();
		t_summary();
		t_history();
		t_irq();
		give_verdict();
	end
endmodule
`default_nettype wire
